// file: rtl/csc_top.sv
/*
 * Clock synthesiser control: multiplier, filter and power control, clock monitor gating,
 * wait-mode stop controls and factory test registers, reached over AHB-Lite.
 * Assumes the analog loop reports frequency error and a clock-fail indication from outside the bus domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "csc_consts.svh"
module csc_top #(
    parameter int unsigned LOCK_CYC = `CSC_LOCK_CYC,
    parameter logic [7:0]  VCO_MIN  = 8'h04
) (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    input  wire logic        i_special_mode,
    input  wire logic        i_wait_mode,
    input  wire logic        i_stop_mode,
    input  wire logic        i_freq_near,
    input  wire logic        i_clock_fail,
    input  wire logic [15:0] i_osc_khz,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic             o_synth_on,
    output logic             o_wide_filter,
    output logic             o_lock,
    output logic             o_track,
    output logic             o_monitor_on,
    output logic             o_monitor_trip,
    output logic             o_irq_div_clear,
    output logic             o_wd_div_clear,
    output logic [31:0]      o_synth_khz,
    output logic [31:0]      o_bus_khz
);
    typedef struct packed {
        logic [7:0]  mult;
        logic [7:0]  refdiv;
        logic [7:0]  sel;
        logic [7:0]  ctrl;
        logic [7:0]  fbyp;
        logic [7:0]  fclk;
        logic        wd_written;
        logic        selfclock;
        logic        bus_act;
        logic        bus_wr;
        logic [7:0]  bus_addr;
        csc_pkg::csc_loop_e loop;
        logic [15:0] lock_cnt;
        logic        lock;
        logic        track;
        logic [1:0]  near_s;
        logic [1:0]  fail_s;
        logic [31:0] rdata;
        logic        mon_on;
        logic        trip;
        logic        irq_clr;
        logic        wd_clr;
        logic [31:0] synth_khz;
        logic [31:0] bus_khz;
    } csc_state_s;

    csc_state_s st_r;
    csc_state_s st_nxt;
    logic [31:0] prod;
    logic [7:0]  eff_mult;
    logic        wr;
    logic [7:0]  wv;
    logic        mult_wr;

    always_comb begin
        st_nxt = st_r;
        wr = st_r.bus_act && st_r.bus_wr;
        wv = i_hwdata[7:0];
        mult_wr = wr && (st_r.bus_addr == `CSC_OFF_MULT) && !st_r.sel[`CSC_SEL_SYNTH];
        st_nxt.near_s = {st_r.near_s[0], i_freq_near};
        st_nxt.fail_s = {st_r.fail_s[0], i_clock_fail};
        st_nxt.bus_act = i_hsel && i_hready && i_htrans[1];
        st_nxt.bus_wr = i_hwrite;
        st_nxt.bus_addr = i_haddr[7:0];
        st_nxt.lock_cnt = (st_r.lock_cnt != 16'h0000) ? st_r.lock_cnt - 16'h0001 : 16'h0000;
        if (wr) begin
            unique case (st_r.bus_addr)
                `CSC_OFF_MULT: begin
                    if (!st_r.sel[`CSC_SEL_SYNTH]) begin // [RQ4] [RQ18]
                        st_nxt.mult = wv;
                        st_nxt.lock = 1'b0; // [RQ5]
                        st_nxt.track = 1'b0;
                        st_nxt.lock_cnt = LOCK_CYC[15:0];
                        // A new multiplier moves the target, so the loop must acquire again.
                        st_nxt.loop = csc_pkg::CSC_ACQUIRE; // [RQ5]
                    end
                end
                `CSC_OFF_REFDIV: st_nxt.refdiv = wv;
                `CSC_OFF_CLOCK_SELECT_CTRL: begin
                    st_nxt.sel[7:2] = wv[7:2];
                    st_nxt.sel[`CSC_SEL_IRQWAI] = wv[`CSC_SEL_IRQWAI]; // [RQ6]
                    if (i_special_mode || !st_r.wd_written) begin // [RQ7]
                        st_nxt.sel[`CSC_SEL_WDWAI] = wv[`CSC_SEL_WDWAI];
                        st_nxt.wd_written = ~i_special_mode;
                    end
                end
                `CSC_OFF_CTRL: begin
                    if (!st_r.selfclock)
                        st_nxt.ctrl[`CSC_CTRL_CME] = wv[`CSC_CTRL_CME]; // [RQ9]
                    if (!st_r.sel[`CSC_SEL_SYNTH])
                        st_nxt.ctrl[`CSC_CTRL_PWR] = wv[`CSC_CTRL_PWR]; // [RQ11]
                    if (!st_r.sel[`CSC_SEL_SWAIT])
                        st_nxt.ctrl[`CSC_CTRL_AUTO] = wv[`CSC_CTRL_AUTO]; // [RQ14]
                    st_nxt.ctrl[`CSC_CTRL_ACQ] = wv[`CSC_CTRL_ACQ]; // [RQ15]
                    st_nxt.ctrl[2:0] = wv[2:0];
                end
                `CSC_OFF_FBYP: if (i_special_mode) st_nxt.fbyp = wv; // [RQ16]
                `CSC_OFF_FCLK: if (i_special_mode) st_nxt.fclk = wv; // [RQ17]
                default: ;
            endcase
        end
        // Wait stop forces auto bandwidth on; it holds that way until wait stop is cleared.
        if (st_nxt.sel[`CSC_SEL_SWAIT])
            st_nxt.ctrl[`CSC_CTRL_AUTO] = 1'b1; // [RQ14]
        st_nxt.ctrl = st_nxt.ctrl & `CSC_CTRL_MASK; // [RQ8]
        st_nxt.mon_on = st_r.ctrl[`CSC_CTRL_CME] && !(i_stop_mode && !st_r.sel[`CSC_SEL_PSTOP]); // [RQ10]
        st_nxt.trip = st_r.mon_on && st_r.fail_s[1]; // [RQ9]
        if (st_r.trip && st_r.ctrl[0])
            st_nxt.selfclock = 1'b1;
        st_nxt.irq_clr = i_wait_mode && st_r.sel[`CSC_SEL_IRQWAI]; // [RQ6]
        st_nxt.wd_clr = i_wait_mode && st_r.sel[`CSC_SEL_WDWAI]; // [RQ7]
        // Loop filter selection; the wide filter is kept while the detector settles.
        if (!(st_r.ctrl[`CSC_CTRL_PWR] || st_r.selfclock)) begin
            st_nxt.loop = csc_pkg::CSC_OFF;
            st_nxt.lock = 1'b0;
            st_nxt.track = 1'b0;
        end else begin
            unique case (st_r.loop)
                csc_pkg::CSC_OFF: begin
                    st_nxt.loop = csc_pkg::CSC_ACQUIRE; // [RQ11]
                    st_nxt.lock_cnt = LOCK_CYC[15:0];
                end
                csc_pkg::CSC_ACQUIRE:
                    if (st_r.near_s[1] && st_r.lock_cnt == 16'h0000 && !mult_wr) begin // [RQ13] [RQ5]
                        st_nxt.loop = csc_pkg::CSC_TRACK;
                        st_nxt.track = 1'b1;
                        st_nxt.lock = 1'b1;
                    end
                csc_pkg::CSC_TRACK:
                    if (!st_r.near_s[1]) begin // [RQ13]
                        st_nxt.loop = csc_pkg::CSC_ACQUIRE;
                        st_nxt.track = 1'b0;
                        st_nxt.lock = 1'b0;
                    end
                default: st_nxt.loop = csc_pkg::CSC_OFF;
            endcase
        end
        eff_mult = (st_r.mult < VCO_MIN) ? VCO_MIN : st_r.mult; // [RQ3]
        prod = 32'({i_osc_khz, 1'b0}) * (32'(eff_mult) + 32'h0000_0001); // [RQ1]
        st_nxt.synth_khz = prod / (32'(st_r.refdiv) + 32'h0000_0001);
        st_nxt.bus_khz = st_r.sel[`CSC_SEL_SYNTH] ? (st_r.synth_khz >> 1) : 32'(i_osc_khz); // [RQ2]
        st_nxt.rdata = 32'h0000_0000;
        if (st_nxt.bus_act && !i_hwrite) begin
            unique case (i_haddr[7:0])
                `CSC_OFF_MULT:   st_nxt.rdata = {24'h00_0000, st_nxt.mult};
                `CSC_OFF_REFDIV: st_nxt.rdata = {24'h00_0000, st_nxt.refdiv};
                `CSC_OFF_CLOCK_SELECT_CTRL: st_nxt.rdata = {24'h00_0000, st_nxt.sel};
                `CSC_OFF_CTRL:   st_nxt.rdata = {24'h00_0000, st_nxt.ctrl}; // [RQ12]
                `CSC_OFF_STATUS: st_nxt.rdata = {28'h000_0000, st_nxt.selfclock, st_nxt.mon_on,
                                                 st_nxt.track, st_nxt.lock};
                `CSC_OFF_FBYP:   st_nxt.rdata = {24'h00_0000,
                                                 i_special_mode ? st_nxt.fbyp : `CSC_FBYP_NORMAL}; // [RQ16]
                `CSC_OFF_FCLK:   st_nxt.rdata = {24'h00_0000,
                                                 i_special_mode ? st_nxt.fclk : `CSC_FCLK_NORMAL}; // [RQ17]
                default:         st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st_r <= '0;
            st_r.ctrl <= `CSC_CTRL_RST; // [RQ8]
            st_r.fclk <= `CSC_FCLK_NORMAL;
            st_r.loop <= csc_pkg::CSC_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Self-clock mode keeps the loop running without touching the latched power bit.
    always_ff @(posedge i_clk) begin
        if (!i_nrst)
            o_synth_on <= 1'b0;
        else
            o_synth_on <= st_r.ctrl[`CSC_CTRL_PWR] || st_r.selfclock; // [RQ12]
    end

    assign o_hrdata        = st_r.rdata;
    assign o_hreadyout     = 1'b1;
    assign o_hresp         = 1'b0;
    assign o_wide_filter   = st_r.ctrl[`CSC_CTRL_AUTO] ? (st_r.loop == csc_pkg::CSC_ACQUIRE)
                                                       : st_r.ctrl[`CSC_CTRL_ACQ];
    assign o_lock          = st_r.lock;
    assign o_track         = st_r.track;
    assign o_monitor_on    = st_r.mon_on;
    assign o_monitor_trip  = st_r.trip;
    assign o_irq_div_clear = st_r.irq_clr;
    assign o_wd_div_clear  = st_r.wd_clr;
    assign o_synth_khz     = st_r.synth_khz;
    assign o_bus_khz       = st_r.bus_khz;

    mult_locked_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (st_r.bus_act && st_r.bus_wr && st_r.bus_addr == `CSC_OFF_MULT && st_r.sel[`CSC_SEL_SYNTH])
        |=> $stable(st_r.mult)) else $error("multiplier changed while selected"); // [RQ4]
    mult_reinit_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (st_r.bus_act && st_r.bus_wr && st_r.bus_addr == `CSC_OFF_MULT && !st_r.sel[`CSC_SEL_SYNTH])
        |=> !st_r.lock && !st_r.track) else $error("detectors not restarted"); // [RQ5]
    ctrl_bit3_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        st_r.ctrl[3] == 1'b0) else $error("control bit 3 set"); // [RQ8]
    stop_monitor_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_stop_mode && !st_r.sel[`CSC_SEL_PSTOP]) |=> !st_r.mon_on) else $error("monitor on in stop"); // [RQ10]
    auto_forced_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        st_r.sel[`CSC_SEL_SWAIT] |-> st_r.ctrl[`CSC_CTRL_AUTO]) else $error("auto not forced"); // [RQ14]
    manual_filter_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !st_r.ctrl[`CSC_CTRL_AUTO] |-> o_wide_filter == st_r.ctrl[`CSC_CTRL_ACQ])
        else $error("manual filter wrong"); // [RQ15]
    fbyp_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_haddr[7:0] == `CSC_OFF_FBYP && !i_special_mode)
        |=> o_hrdata == 32'h0000_0000) else $error("test reg 1 visible"); // [RQ16]
    fclk_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_haddr[7:0] == `CSC_OFF_FCLK && !i_special_mode)
        |=> o_hrdata == 32'h0000_0080) else $error("test reg 2 visible"); // [RQ17]
    selfclock_on_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        st_r.selfclock |=> o_synth_on) else $error("synth off in self-clock"); // [RQ12]
    wd_wait_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wait_mode && st_r.sel[`CSC_SEL_WDWAI]) |=> o_wd_div_clear) else $error("watchdog not held"); // [RQ7]
endmodule
`default_nettype wire

// file: rtl/csc_consts.svh
/*
 * Register offsets, field positions, reset values and timing counts for the clock synthesiser control block.
 * Assumes an AHB-Lite slave with 32-bit data; every register takes one aligned word.
 */
//
// Behaviour
// RQ1: Running synthesiser frequency is 2 * osc * (multiplier + 1) / (ref divider + 1).
// RQ2: With synthesiser selected, bus clock is synthesiser frequency divided by two.
// RQ3: Synthesiser frequency never falls below the minimum oscillator frequency; the code only floors the multiplier at VCO_MIN.
// RQ4: Multiplier is always readable; writes ignored while synthesiser clock is selected.
// RQ5: An accepted multiplier write restarts the lock and track detectors.
// RQ6: Periodic irq wait stop bit halts and clears its dividers in wait; write anytime.
// RQ7: Watchdog wait stop halts watchdog in wait; write once normally, anytime special.
// RQ8: Control bits at 7,6,5,4,2,1,0, bit 3 reads zero, reset 1111_0001.
// RQ9: Clock monitor enable arms loss detection; writes ignored in self-clock mode.
// RQ10: In full stop mode the clock monitor is off whatever its enable says.
// RQ11: Power bit switches synthesiser; writes ignored while selected; auto locks alone.
// RQ12: Self-clock mode forces synthesiser on; power bit reads its latched value.
// RQ13: Auto bandwidth picks wide or narrow filter by distance from target.
// RQ14: Auto off hands filter to software; auto writes ignored and forced set under wait stop.
// RQ15: Manual filter: 0 narrow, 1 wide; writable anytime; ignored under auto.
// RQ16: First factory test register reads zero outside special modes; writes special only.
// RQ17: Second factory test register reads 0x80 outside special modes; writes special only.
// RQ18: A blocked write changes nothing and has no side effect.
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH
`define CSC_OFF_MULT      8'h00
`define CSC_OFF_REFDIV    8'h04
`define CSC_OFF_CLOCK_SELECT_CTRL    8'h08
`define CSC_OFF_CTRL      8'h0C
`define CSC_OFF_STATUS    8'h10
`define CSC_OFF_FBYP      8'h14
`define CSC_OFF_FCLK      8'h18
`define CSC_SEL_SYNTH     7
`define CSC_SEL_PSTOP     6
`define CSC_SEL_SWAIT     3
`define CSC_SEL_IRQWAI    1
`define CSC_SEL_WDWAI     0
`define CSC_CTRL_CME      7
`define CSC_CTRL_PWR      6
`define CSC_CTRL_AUTO     5
`define CSC_CTRL_ACQ      4
`define CSC_CTRL_RST      8'hF1
`define CSC_CTRL_MASK     8'hF7
`define CSC_FCLK_NORMAL   8'h80
`define CSC_FBYP_NORMAL   8'h00
`define CSC_LOCK_NS       1000
`define CSC_CLK_NS        8
`define CSC_LOCK_CYC      ((`CSC_LOCK_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS)
`endif

// file: rtl/csc_pkg.sv
/*
 * Types for the clock synthiser control block.
 * Assumes csc_consts.svh supplies the numbers.
 */
package csc_pkg;
    typedef enum logic [1:0] {CSC_OFF, CSC_ACQUIRE, CSC_TRACK} csc_loop_e;
    typedef enum logic [1:0] {CSC_IDLE, CSC_WRITE, CSC_READ} csc_bus_e;
endpackage

// file: verification/csc_top_tb.sv
/*
 * Self-checking testbench for the clock synthesiser control block, driving AHB-Lite single word transfers.
 * Assumes csc_consts.svh for offsets and a zero wait-state slave whose hreadyout feeds back as hready.
 */
`timescale 1ns/1ps
`default_nettype none
`include "csc_consts.svh"
module csc_top_tb;
    logic        i_clk = 1'h0;
    logic        i_nrst, hsel, hwrite, spec, wmode, smode, fnear, cfail, rd_dp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] osc;
    logic [31:0] haddr, hwdata, hrdata, skhz, bkhz, tv, m, r, ex;
    logic        hrdy, hresp, son, wide, lock, track, mon, trip, irqc, wdc;
    int          fails, tests_run, seed;
    logic [31:0] expq[$];

    always #4 i_clk = ~i_clk;

    csc_top #(.LOCK_CYC(4), .VCO_MIN(8'h04)) dut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
        .i_special_mode(spec), .i_wait_mode(wmode), .i_stop_mode(smode), .i_freq_near(fnear),
        .i_clock_fail(cfail), .i_osc_khz(osc), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
        .o_synth_on(son), .o_wide_filter(wide), .o_lock(lock), .o_track(track), .o_monitor_on(mon),
        .o_monitor_trip(trip), .o_irq_div_clear(irqc), .o_wd_div_clear(wdc), .o_synth_khz(skhz),
        .o_bus_khz(bkhz)
    );

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Read data stands only in the data phase, so the watcher samples it at the edge that closes that phase.
    always @(posedge i_clk) begin
        if (rd_dp) begin
            chk(expq.pop_front(), hrdata);
        end
        rd_dp <= hsel && htrans[1] && hrdy === 1'h1 && !hwrite;
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge i_clk);
        while (hrdy !== 1'h1) @(posedge i_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge i_clk);
        while (hrdy !== 1'h1) @(posedge i_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'h0, a, 32'h0);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    initial begin
        #(8 * 4000);
        fails++;
        stop_test();
    end

    initial begin
        seed = 32'h2452AD23;
        {hsel, hwrite, spec, wmode, smode, fnear, cfail, rd_dp, i_nrst} = 9'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        osc = 16'h1F40;
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'h1;
        rd(`CSC_OFF_CTRL, 32'hF1);
        rd(`CSC_OFF_FCLK, 32'h80);
        rd(`CSC_OFF_FBYP, 32'h00);
        wr(`CSC_OFF_CLOCK_SELECT_CTRL, 32'h03);
        wr(`CSC_OFF_CLOCK_SELECT_CTRL, 32'h00);
        rd(`CSC_OFF_CLOCK_SELECT_CTRL, 32'h01);
        wmode <= 1'h1;
        cyc(3);
        chk(1'h0, irqc);
        chk(1'h1, wdc);
        wmode <= 1'h0;
        spec <= 1'h1;
        wr(`CSC_OFF_CLOCK_SELECT_CTRL, 32'h02);
        rd(`CSC_OFF_CLOCK_SELECT_CTRL, 32'h02);
        wmode <= 1'h1;
        cyc(3);
        chk(1'h1, irqc);
        chk(1'h0, wdc);
        wmode <= 1'h0;
        tv = $random(seed) & 32'hFF;
        wr(`CSC_OFF_FBYP, tv);
        wr(`CSC_OFF_FCLK, tv ^ 32'hFF);
        rd(`CSC_OFF_FBYP, tv);
        rd(`CSC_OFF_FCLK, tv ^ 32'hFF);
        spec <= 1'h0;
        wr(`CSC_OFF_FBYP, 32'h5A);
        rd(`CSC_OFF_FBYP, 32'h00);
        rd(`CSC_OFF_FCLK, 32'h80);
        spec <= 1'h1;
        rd(`CSC_OFF_FBYP, tv);
        spec <= 1'h0;
        wr(`CSC_OFF_CTRL, 32'hFF);
        rd(`CSC_OFF_CTRL, 32'hF7);
        wr(`CSC_OFF_CTRL, 32'h50);
        cyc(2);
        chk(1'h1, wide);
        wr(`CSC_OFF_CTRL, 32'h40);
        cyc(2);
        chk(1'h0, wide);
        wr(`CSC_OFF_CTRL, 32'h70);
        cyc(10);
        chk(1'h1, wide);
        fnear <= 1'h1;
        cyc(20);
        chk(1'h0, wide);
        // Multiplier 1 sits below the floor, so the first pass always probes the clamp.
        for (int i = 0; i < 4; i++) begin
            m = (i == 0) ? 32'h1 : $random(seed) & 32'hFF;
            r = $random(seed) & 32'hFF;
            osc <= 16'($random(seed));
            wr(`CSC_OFF_REFDIV, r);
            wr(`CSC_OFF_MULT, m);
            cyc(1);
            chk(1'h0, lock);
            cyc(20);
            chk(1'h1, lock);
            ex = 32'(64'd2 * osc * ((m < 32'h4 ? 32'h4 : m) + 1) / (r + 1));
            chk(ex, skhz);
            chk({16'h0, osc}, bkhz);
            rd(`CSC_OFF_MULT, m);
        end
        wr(`CSC_OFF_CLOCK_SELECT_CTRL, 32'h80);
        cyc(3);
        chk(ex / 2, bkhz);
        wr(`CSC_OFF_MULT, m ^ 32'h1);
        cyc(1);
        chk(1'h1, lock);
        rd(`CSC_OFF_MULT, m);
        wr(`CSC_OFF_CTRL, 32'h30);
        cyc(2);
        chk(1'h1, son);
        rd(`CSC_OFF_CTRL, 32'h70);
        wr(`CSC_OFF_CLOCK_SELECT_CTRL, 32'h08);
        wr(`CSC_OFF_CTRL, 32'h40);
        rd(`CSC_OFF_CTRL, 32'h60);
        wr(`CSC_OFF_CLOCK_SELECT_CTRL, 32'h00);
        wr(`CSC_OFF_CTRL, 32'hC0);
        cyc(3);
        chk(1'h1, mon);
        smode <= 1'h1;
        cyc(3);
        chk(1'h0, mon);
        smode <= 1'h0;
        wr(`CSC_OFF_CTRL, 32'h81);
        cyc(2);
        chk(1'h0, son);
        cfail <= 1'h1;
        cyc(8);
        chk(1'h1, son);
        wr(`CSC_OFF_CTRL, 32'h01);
        rd(`CSC_OFF_CTRL, 32'h81);
        cfail <= 1'h0;
        i_nrst <= 1'h0;
        cyc(2);
        i_nrst <= 1'h1;
        rd(`CSC_OFF_CTRL, 32'hF1);
        cyc(2);
        stop_test();
    end
endmodule
`default_nettype wire
